//--- shared_periph_regs.svh
// Constants of the shared peripheral I/O controller: register map, field positions, widths.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SHARED_PERIPH_REGS_SVH
`define SHARED_PERIPH_REGS_SVH
// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_LAST_ADDR 4'h8
`define REG_RESP 4'hC
`define CTRL_FMT16_BIT 0
`define CTRL_FORCE_BUSY_BIT 1
// ----------------------------------------------------------------------
// Host word fields
// ----------------------------------------------------------------------
`define WORD_W 24
`define SEL_CODE_LSB 1
`define SEL_CODE_MSB 6
`define CHAN_LOW_BIT 13
`define CHAN_HIGH_BIT 12
`define ADDR9_MSB 8
`define ADDR8_MSB 7
`define DATA_MSB 23
`define DATA16_LSB 8
`define DATA15_LSB 9
`define ADDR_W 9
`define DATA_W 16
`define STATUS_WIRE_W 23
`define NUM_CHAN 4
`define DEFAULT_NUM_DEV 8
`define DEFAULT_SEL_CODE 6'h15
`endif

//--- shared_periph_pkg.sv
// Types shared by the controller modules: sequencer states and device kinds.
// Assumes the constants header is on the include path.
`include "shared_periph_regs.svh"
package shared_periph_pkg;
  // Sequencer states, Gray coded along idle, sync, delay, done
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_SYNC = 2'h1,
    ST_DELAY = 2'h3,
    ST_DONE = 2'h2
  } ctl_state_t;
  // Kind of each attached device
  typedef enum logic [1:0]
  {
    DEV_OUT = 2'h0,
    DEV_IN = 2'h1,
    DEV_INOUT = 2'h2,
    DEV_FUNC = 2'h3
  } dev_type_t;
endpackage : shared_periph_pkg

//--- decode_if.sv
// Carrier between the sequencer and the address decoder.
// Assumes one sequencer drives it and one decoder answers.
interface decode_if #(parameter int NUM_DEV = 8);
  logic enable;
  logic [8:0] addr;
  logic [15:0] out_data;
  logic [NUM_DEV-1:0] sel;
  logic [23:0] in_bus;
  modport ctl (output enable, output addr, output out_data, input sel, input in_bus);
  modport dec (input enable, input addr, input out_data, output sel, output in_bus);
endinterface : decode_if

//--- pin_sync.sv
// Three-stage synchroniser for host pins; a bit changes once stages two and three agree.
// Assumes the inputs come from the host clock domain.
module pin_sync #(parameter int WIDTH = 8)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Pins and filtered value
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed
  {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_t;
  sync_t r;
  sync_t next_r;

  // Shift chain; stage one is read only by stage two
  always_comb
  begin
    next_r = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign q_o = r.q;
endmodule : pin_sync

//--- line_decoder.sv
// One-of-N address decoder with per-device AND gating onto the data buses.
// Assumes devices sit on the controller clock; a direction that a device's kind does not use is tied to zero.
module line_decoder
  import shared_periph_pkg::*;
#(
  parameter int NUM_DEV = 8,
  parameter logic [2*NUM_DEV-1:0] DEV_TYPES = {NUM_DEV{2'h2}}
)
(
  // Sequencer side
  decode_if.dec bus,
  // Device side
  output logic [NUM_DEV*16-1:0] dev_out_o,
  input wire logic [NUM_DEV*24-1:0] dev_in_i
);
  logic [NUM_DEV*24-1:0] gated_in;

  // Address match for one line
  function automatic logic line_hit(input logic [8:0] a, input int idx);
    line_hit = (a == idx[8:0]);
  endfunction : line_hit

  // Per device decode and AND gates
  genvar g;
  generate
    for (g = 0; g < NUM_DEV; g++)
    begin : g_dev
      localparam logic [1:0] KIND = DEV_TYPES[2*g +: 2];
      assign bus.sel[g] = bus.enable && line_hit(bus.addr, g);
      assign dev_out_o[16*g +: 16] = (KIND == DEV_OUT || KIND == DEV_INOUT) ?
        (bus.out_data & {16{bus.sel[g]}}) : 16'h0000;
      assign gated_in[24*g +: 24] = (KIND == DEV_IN || KIND == DEV_INOUT) ?
        (dev_in_i[24*g +: 24] & {24{bus.sel[g]}}) : 24'h00_0000;
    end
  endgenerate

  // Wired-OR of the gated inputs onto the input bus
  always_comb
  begin
    bus.in_bus = 24'h00_0000;
    for (int i = 0; i < NUM_DEV; i++)
      bus.in_bus = bus.in_bus | gated_in[24*i +: 24];
  end
endmodule : line_decoder

//--- shared_periph_ctrl.sv
// Top of the shared peripheral I/O controller: host command sequencer, registers, interrupts.
// Assumes host pins are asynchronous and held until completion is seen; devices are synchronous.
//
// Chosen here: the register addresses and strobed register access.
`include "shared_periph_regs.svh"
module shared_periph_ctrl
  import shared_periph_pkg::*;
#(
  parameter int NUM_DEV = `DEFAULT_NUM_DEV,
  parameter logic [2*NUM_DEV-1:0] DEV_TYPES = {NUM_DEV{2'h2}},
  parameter logic [5:0] SELECT_CODE = `DEFAULT_SEL_CODE // Arbitrary controller code
)
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Host command pins
  input wire logic SELECT_CMD_I,
  input wire logic XFER_CMD_I,
  input wire logic STATUS_REQ_I,
  input wire logic DISCONNECT_I,
  input wire logic [`WORD_W-1:0] HOST_OUTPUT_WORD_BUS_I,
  input wire logic [`NUM_CHAN-1:0] CHANNEL_ENABLE_LINE_I,
  input wire logic CONTROLLER_BUSY_I,
  // Host answer
  output logic OPERATION_COMPLETE_O,
  output logic [`WORD_W-1:0] RESPONSE_WORD_O,
  output logic [`NUM_CHAN-1:0] INTERRUPT_REQUEST_LINE_O,
  // Devices
  output logic [NUM_DEV-1:0] DEV_SELECT_O,
  output logic [NUM_DEV*16-1:0] DEV_OUT_DATA_O,
  input wire logic [NUM_DEV*24-1:0] DEV_IN_DATA_I,
  input wire logic [NUM_DEV-1:0] DEV_ATTENTION_I,
  input wire logic [`STATUS_WIRE_W-1:0] STATUS_WIRE_I,
  // Register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O
);
  import shared_periph_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    ctl_state_t state;
    logic online;
    logic chan_lo;
    logic chan_hi;
    logic fmt16;
    logic force_busy;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] out_data;
    logic [`WORD_W-1:0] resp;
    logic complete;
    logic [`NUM_CHAN-1:0] irq;
    logic [31:0] rdata;
  } ctl_regs_t;

  ctl_regs_t r;
  ctl_regs_t next_r;

  localparam int SYNC_W = `WORD_W + `NUM_CHAN + 5;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins;
  logic s_sel;
  logic s_xfer;
  logic s_stat;
  logic s_disc;
  logic s_busy;
  logic [`WORD_W-1:0] s_word;
  logic [`NUM_CHAN-1:0] s_en;
  logic cmd_here;
  logic channel_match;
  logic busy;
  logic [1:0] chan_idx;
  logic [`WORD_W-1:0] status_word;
  logic [`ADDR_W-1:0] word_addr;
  logic [`DATA_W-1:0] word_data;

  // ----------------------------------------------------------------------
  // Host pin synchronisers
  // ----------------------------------------------------------------------
  assign pins_raw = {SELECT_CMD_I, XFER_CMD_I, STATUS_REQ_I, DISCONNECT_I,
                     CONTROLLER_BUSY_I, CHANNEL_ENABLE_LINE_I, HOST_OUTPUT_WORD_BUS_I};

  pin_sync #(.WIDTH(SYNC_W)) u_sync
  (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .d_i(pins_raw),
    .q_o(pins)
  );

  // Unpack the filtered pins
  assign {s_sel, s_xfer, s_stat, s_disc, s_busy, s_en, s_word} = pins;

  // ----------------------------------------------------------------------
  // Address decoder
  // ----------------------------------------------------------------------
  decode_if #(.NUM_DEV(NUM_DEV)) dec_bus ();

  line_decoder #(.NUM_DEV(NUM_DEV), .DEV_TYPES(DEV_TYPES)) u_dec
  (
    .bus(dec_bus.dec),
    .dev_out_o(DEV_OUT_DATA_O),
    .dev_in_i(DEV_IN_DATA_I)
  );

  // Decoder lines live only in the sync and delay steps of a transfer
  assign dec_bus.enable = (r.state == ST_SYNC) || (r.state == ST_DELAY);
  assign dec_bus.addr = r.addr;
  assign dec_bus.out_data = r.out_data;
  assign DEV_SELECT_O = dec_bus.sel;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Select addressed to this controller
  assign cmd_here = s_sel && (s_word[`SEL_CODE_MSB:`SEL_CODE_LSB] == SELECT_CODE);
  assign chan_idx = {r.chan_hi, r.chan_lo};
  // Transfer only while on-line and its enable line matches the channel
  assign channel_match = r.online && s_en[chan_idx];
  assign busy = s_busy || r.force_busy;
  // Top bit reports power on, the rest come from the attached options
  assign status_word = {1'b1, STATUS_WIRE_I};
  // Split of the host word by format
  assign word_addr = r.fmt16 ? {1'b0, s_word[`ADDR8_MSB:0]} : s_word[`ADDR9_MSB:0];
  assign word_data = r.fmt16 ? s_word[`DATA_MSB:`DATA16_LSB] :
                     {1'b0, s_word[`DATA_MSB:`DATA15_LSB]};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.rdata = 32'h0000_0000;
    // Interrupt on the held channel line while any device calls
    for (int k = 0; k < `NUM_CHAN; k++)
      next_r.irq[k] = r.online && (chan_idx == k[1:0]) && (|DEV_ATTENTION_I);
    case (r.state)
      ST_IDLE:
      begin
        if (cmd_here && s_stat)
        begin
          // Select for status only
          next_r.resp = status_word;
          next_r.complete = 1'b1;
          next_r.state = ST_DONE;
        end
        else if (cmd_here)
        begin
          // Go on-line and latch the channel
          next_r.online = 1'b1;
          next_r.chan_lo = s_word[`CHAN_LOW_BIT];
          next_r.chan_hi = s_word[`CHAN_HIGH_BIT];
          next_r.resp = status_word;
          next_r.complete = 1'b1;
          next_r.state = ST_DONE;
        end
        else if (s_xfer && channel_match && s_stat)
        begin
          // Transfer for status only
          next_r.resp = status_word;
          next_r.complete = 1'b1;
          next_r.state = ST_DONE;
        end
        else if (s_xfer && channel_match)
        begin
          // Capture address and data of the transfer
          next_r.addr = word_addr;
          next_r.out_data = word_data;
          next_r.state = ST_SYNC;
        end
        else
        begin
          next_r.state = ST_IDLE;
        end
      end
      ST_SYNC:
      begin
        // Hold here while the controller is busy
        if (!busy)
          next_r.state = ST_DELAY;
      end
      ST_DELAY:
      begin
        // One clock for decoding, then return the input word
        next_r.resp = dec_bus.in_bus;
        next_r.complete = 1'b1;
        if (s_disc)
        begin
          next_r.online = 1'b0;
          next_r.chan_lo = 1'b0;
          next_r.chan_hi = 1'b0;
        end
        next_r.state = ST_DONE;
      end
      ST_DONE:
      begin
        // Completion stands until the host drops its command
        if (!s_sel && !s_xfer)
        begin
          next_r.complete = 1'b0;
          next_r.state = ST_IDLE;
        end
      end
      default:
      begin
        next_r.state = ST_IDLE;
        next_r.complete = 1'b0;
      end
    endcase
    // Register writes
    if (REG_WR_I && REG_ADDR_I == `REG_CTRL)
    begin
      next_r.fmt16 = REG_WDATA_I[`CTRL_FMT16_BIT];
      next_r.force_busy = REG_WDATA_I[`CTRL_FORCE_BUSY_BIT];
    end
    // Register reads, answered in the next cycle
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `REG_CTRL: next_r.rdata = {30'h0000_0000, r.force_busy, r.fmt16};
        `REG_STATUS: next_r.rdata = {27'h000_0000, r.state, r.chan_hi, r.chan_lo, r.online};
        `REG_LAST_ADDR: next_r.rdata = {23'h00_0000, r.addr};
        `REG_RESP: next_r.rdata = {8'h00, r.resp};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      r <= '0;
    else
      r <= next_r;
  end

  // Outputs
  assign OPERATION_COMPLETE_O = r.complete;
  assign RESPONSE_WORD_O = r.resp;
  assign INTERRUPT_REQUEST_LINE_O = r.irq;
  assign REG_RDATA_O = r.rdata;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  // Going on-line only from idle on a select addressed here
  property p_online_from_select;
    $rose(r.online) |-> $past(r.state) == ST_IDLE && $past(cmd_here);
  endproperty
  a_online_from_select: assert property (p_online_from_select)
    else $error("on-line without a select");

  // Idle with no command stays idle and quiet
  property p_passive;
    (r.state == ST_IDLE && !s_sel && !s_xfer) |=> r.state == ST_IDLE && !r.complete;
  endproperty
  a_passive: assert property (p_passive)
    else $error("controller acted on its own");

  // Status select answers next cycle with the status word
  property p_status;
    (r.state == ST_IDLE && cmd_here && s_stat) |=>
      r.complete && r.resp == $past(status_word);
  endproperty
  a_status: assert property (p_status)
    else $error("status word not returned");

  // Interrupt raised on the held line whenever on-line and a device calls
  property p_irq;
    $past(|DEV_ATTENTION_I && r.online) |-> r.irq[$past(chan_idx)];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing on channel");

  // Disconnect transfer goes off-line at completion
  property p_disconnect;
    (r.state == ST_DELAY && s_disc) |=> !r.online && r.complete;
  endproperty
  a_disconnect: assert property (p_disconnect)
    else $error("disconnect ignored");

  // At most one decoded line at any time
  property p_onehot;
    $onehot0(DEV_SELECT_O);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("several device lines active");

  // Channel bits captured from the select word
  property p_chan_store;
    $rose(r.online) |-> r.chan_lo == $past(s_word[`CHAN_LOW_BIT]) &&
      r.chan_hi == $past(s_word[`CHAN_HIGH_BIT]);
  endproperty
  a_chan_store: assert property (p_chan_store)
    else $error("channel assignment not stored");

  // Unmatched transfer is ignored
  property p_match;
    (r.state == ST_IDLE && s_xfer && !s_sel && !channel_match) |=> r.state == ST_IDLE;
  endproperty
  a_match: assert property (p_match)
    else $error("unmatched transfer processed");

  // Completion comes exactly two cycles after a free sync step
  property p_delay;
    (r.state == ST_SYNC && !busy) |=> !r.complete ##1 r.complete;
  endproperty
  a_delay: assert property (p_delay)
    else $error("completion not delayed one clock");

  // Busy holds the sequencer in sync with no completion
  property p_busy;
    (r.state == ST_SYNC && busy) |=> r.state == ST_SYNC && !r.complete;
  endproperty
  a_busy: assert property (p_busy)
    else $error("completion while busy");

  // Device lines only during a transfer
  property p_lines;
    (r.state == ST_IDLE || r.state == ST_DONE) |-> DEV_SELECT_O == '0;
  endproperty
  a_lines: assert property (p_lines)
    else $error("device line outside transfer");
endmodule : shared_periph_ctrl

//--- host_channel_model.sv
// Host side of the shared I/O channel: issues select and transfer commands.
// Assumes one clock shared with the controller; pins change just after a rising edge.
module host_channel_model
(
  // Clock
  input wire logic clk_i,
  // Answer from the controller
  input wire logic complete_i,
  input wire logic [23:0] response_i,
  // Command pins
  output logic select_o,
  output logic xfer_o,
  output logic status_req_o,
  output logic disconnect_o,
  output logic [23:0] word_o,
  output logic [3:0] enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins from time zero
  initial
  begin
    select_o = 1'b0;
    xfer_o = 1'b0;
    status_req_o = 1'b0;
    disconnect_o = 1'b0;
    word_o = 24'h00_0000;
    enable_o = 4'h0;
  end
  // One command held until completion or the limit, then released
  task automatic command(input logic sel, input logic stat, input logic disc,
    input logic [23:0] word, input logic [3:0] en, input int limit,
    output logic [23:0] resp, output int lat, output bit ok);
    ok = 0;
    lat = 0;
    resp = 24'h00_0000;
    @(posedge clk_i);
    select_o <= sel;
    xfer_o <= ~sel;
    status_req_o <= stat;
    disconnect_o <= disc;
    word_o <= word;
    enable_o <= sel ? 4'h0 : en;
    while (!ok && lat < limit)
    begin
      @(negedge clk_i);
      lat++;
      if (complete_i === 1'b1)
      begin
        ok = 1;
        resp = response_i;
      end
    end
    // Release; the word bus no longer shows the last value
    @(posedge clk_i);
    select_o <= 1'b0;
    xfer_o <= 1'b0;
    status_req_o <= 1'b0;
    disconnect_o <= 1'b0;
    word_o <= ~word;
    enable_o <= 4'h0;
    for (int i = 0; i < 12 && complete_i !== 1'b0; i++)
      @(posedge clk_i);
    repeat (6) @(posedge clk_i);
  endtask : command
endmodule : host_channel_model

//--- shared_peripheral_io_controller_tb_top.sv
// Self-checking bench of the shared peripheral I/O controller.
// Assumes the host model above and default build of eight devices.
module shared_peripheral_io_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic busy = 1'b0;
  logic h_sel, h_xfer, h_stat, h_disc, complete;
  logic [23:0] h_word, resp;
  logic [3:0] h_en, irq;
  logic [7:0] dev_sel, attn = 8'h00, sel_or;
  logic [127:0] dev_out, out_cap;
  logic [191:0] dev_in;
  logic [22:0] status_wire = 23'h2a_5c3c;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, rdata, rd;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [23:0] hresp;
  int hlat, lat_sel, sel_cnt, n_mismatch = 0, n_checks = 0;
  bit hok;
  // ----------------------------------------------------------------
  // Clock, devices, design and host
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  initial
    for (int i = 0; i < 8; i++)
      dev_in[i*24+:24] = 24'ha5_0000 | 24'(i * 'h111);
  // Device 6 is input only and device 7 function only; the rest are input and output
  shared_periph_ctrl #(.DEV_TYPES(16'hdaaa)) dut (.CLK_I(clk), .RESETN_I(resetn),
    .SELECT_CMD_I(h_sel),
    .XFER_CMD_I(h_xfer), .STATUS_REQ_I(h_stat), .DISCONNECT_I(h_disc),
    .HOST_OUTPUT_WORD_BUS_I(h_word), .CHANNEL_ENABLE_LINE_I(h_en),
    .CONTROLLER_BUSY_I(busy), .OPERATION_COMPLETE_O(complete), .RESPONSE_WORD_O(resp),
    .INTERRUPT_REQUEST_LINE_O(irq), .DEV_SELECT_O(dev_sel), .DEV_OUT_DATA_O(dev_out),
    .DEV_IN_DATA_I(dev_in), .DEV_ATTENTION_I(attn), .STATUS_WIRE_I(status_wire),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(wr_stb),
    .REG_RD_I(rd_stb), .REG_RDATA_O(rdata));
  host_channel_model host (.clk_i(clk), .complete_i(complete), .response_i(resp),
    .select_o(h_sel), .xfer_o(h_xfer), .status_req_o(h_stat), .disconnect_o(h_disc),
    .word_o(h_word), .enable_o(h_en));
  // Record decoded lines and gated output data whenever a line is up
  always @(negedge clk)
    if (dev_sel !== 8'h00)
    begin
      sel_or = sel_or | dev_sel;
      sel_cnt++;
      out_cap = dev_out;
    end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    rd = rdata;
  endtask : reg_rd
  task automatic cmd(input logic sel, input logic stat, input logic disc,
    input logic [23:0] w, input logic [3:0] en, input int limit);
    sel_or = 8'h00;
    sel_cnt = 0;
    host.command(sel, stat, disc, w, en, limit, hresp, hlat, hok);
  endtask : cmd
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("complete_rst", complete, 0);
    check("irq_rst", irq, 0);
    check("sel_rst", dev_sel, 0);
    reg_rd(4'h4);
    check("status_rst", rd, 0);
    cmd(0, 0, 0, 24'h00_0002, 4'hf, 20);
    check("offline_xfer", hok, 0);
    check("offline_lines", sel_or, 0);
  endtask : t_reset
  task automatic t_select();
    cmd(1, 0, 0, 24'h00_202c, 4'h0, 20);
    check("other_code", hok, 0);
    cmd(1, 0, 0, 24'h00_202a, 4'h0, 20);
    lat_sel = hlat;
    check("sel_ok", hok, 1);
    check("sel_status", hresp, {1'b1, status_wire});
    reg_rd(4'h4);
    check("chan_store", rd[2:0], 3'b011);
    repeat (10) @(posedge clk);
    check("passive", sel_or, 0);
    attn <= 8'h10;
    repeat (4) @(posedge clk);
    check("irq_on", irq, 4'b0010);
    attn <= 8'h00;
    repeat (4) @(posedge clk);
    check("irq_off", irq, 0);
  endtask : t_select
  task automatic t_xfer15();
    cmd(0, 0, 0, {15'h5a5a, 9'h003}, 4'h1, 20);
    check("wrong_chan", hok, 0);
    cmd(0, 0, 0, {15'h5a5a, 9'h003}, 4'h2, 40);
    check("xfer_ok", hok, 1);
    check("xfer_in", hresp, dev_in[3*24+:24]);
    check("one_line", sel_or, 8'h08);
    check("line_span", sel_cnt, 2);
    check("out_data", out_cap[3*16+:16], 16'h5a5a);
    check("out_gate", |(out_cap & ~(128'hffff << 48)), 0);
    check("latency", hlat, lat_sel + 2);
    reg_rd(4'h8);
    check("last_addr", rd, 32'h0000_0003);
    cmd(0, 0, 0, {15'h0001, 9'h103}, 4'h2, 40);
    check("no_line", sel_or, 0);
    check("no_input", hresp, 0);
    cmd(0, 1, 0, 24'h00_0001, 4'h2, 40);
    check("xfer_status", hresp, {1'b1, status_wire});
    check("status_lines", sel_or, 0);
    reg_rd(4'hC);
    check("resp_reg", rd, {1'b1, status_wire});
  endtask : t_xfer15
  task automatic t_busy();
    busy <= 1'b1;
    fork
      cmd(0, 0, 0, 24'h00_0004, 4'h2, 60);
      begin
        repeat (20) @(posedge clk);
        busy <= 1'b0;
      end
    join
    check("busy_ok", hok, 1);
    check("busy_hold", hlat >= 20, 1);
    check("busy_data", hresp, dev_in[4*24+:24]);
    // Busy forced from the register port while an input-only device is addressed
    fork
      cmd(0, 0, 0, {15'h7fff, 9'h006}, 4'h2, 60);
      begin
        reg_wr(4'h0, 32'h0000_0002);
        repeat (12) @(posedge clk);
        reg_wr(4'h0, 32'h0000_0000);
      end
    join
    check("fbusy_ok", hok, 1);
    check("fbusy_hold", hlat >= 15, 1);
    check("in_only_data", hresp, dev_in[6*24+:24]);
    check("in_only_out", |out_cap, 0);
    // Function-only device: line only, no data either way
    cmd(0, 0, 0, {15'h1234, 9'h007}, 4'h2, 40);
    check("func_line", sel_or, 8'h80);
    check("func_out", |out_cap, 0);
    check("func_in", hresp, 0);
  endtask : t_busy
  task automatic t_fmt16();
    reg_wr(4'h0, 32'h0000_0001);
    reg_rd(4'h0);
    check("ctrl_rw", rd[1:0], 2'b01);
    reg_rd(4'h2);
    check("unmapped", rd, 0);
    cmd(0, 0, 0, {16'hbeef, 8'h05}, 4'h2, 40);
    check("fmt16_line", sel_or, 8'h20);
    check("fmt16_data", out_cap[5*16+:16], 16'hbeef);
    reg_wr(4'h0, 32'h0000_0000);
  endtask : t_fmt16
  task automatic t_disconnect();
    cmd(0, 0, 1, 24'h00_0000, 4'h2, 40);
    check("disc_ok", hok, 1);
    reg_rd(4'h4);
    check("offline", rd[2:0], 0);
    attn <= 8'h01;
    repeat (4) @(posedge clk);
    check("irq_freed", irq, 0);
    cmd(0, 0, 0, 24'h00_0001, 4'h2, 20);
    check("after_disc", hok, 0);
  endtask : t_disconnect
  // Status-only select, then on-line on channel 3 and a reset in mid-run
  task automatic t_midreset();
    cmd(1, 1, 0, 24'h00_202a, 4'h0, 20);
    check("sel_stat", hresp, {1'b1, status_wire});
    reg_rd(4'h4);
    check("sel_stat_off", rd[0], 0);
    cmd(1, 0, 0, 24'h00_302a, 4'h0, 20);
    check("chan3_irq", irq, 4'b1000);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq_midrst", irq, 0);
    resetn <= 1'b1;
    @(posedge clk);
    reg_rd(4'h4);
    check("status_midrst", rd, 0);
    check("irq_after_rst", irq, 0);
  endtask : t_midreset
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_select();
    t_xfer15();
    t_busy();
    t_fmt16();
    t_disconnect();
    t_midreset();
    final_report();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule : shared_peripheral_io_controller_tb_top
